/* common/sleep_consts.svh */
`ifndef SLEEP_CONSTS_SVH
`define SLEEP_CONSTS_SVH
// Overview of operation
// [RQ1] Mode 001 stops CPU, flash, I/O clocks; ADC and async clocks run.
// [RQ2] Entering noise reduction with ADC enabled starts a conversion.
// [RQ3] Noise reduction wakes on ADC, resets, TWI, timer 2, STORE_PROGRAM_MEMORY/EEPROM, ext lines.
// [RQ4] Mode 010 power-down stops oscillator and all generated clocks.
// [RQ5] Power-down wakes only on resets, TWI match, level line 0/1, line 2.
// [RQ6] External level wake source must hold its level long enough.
// [RQ7] Power-down wake waits a start-up delay chosen by clock source fuses.
// [RQ8] Mode 011 power-save is power-down with async clock kept when selected.
// [RQ9] Power-save wakes on timer 2 events only if enabled and global enable set.
// [RQ10] Timer 2 contents undefined after power-save wake when not async.
// [RQ11] Mode 110 with crystal is standby: oscillator runs, six-cycle wake.
// [RQ12] Mode 111 with crystal is extended standby, six-cycle wake.
// [RQ13] Deep modes accept only line 2 and level lines 1 and 0.
// [RQ14] ADC stays enabled in sleep; re-enable forces extended conversion.
// [RQ15] Comparator disabled in deep modes unless it uses internal reference.
// [RQ16] Fuse-enabled brown-out detector stays enabled in every mode.
// [RQ17] Enabled watchdog keeps running in every sleep mode.
// [RQ18] Internal reference on only while BOD, comparator or ADC needs it.
// [RQ19] Input buffers off when I/O and ADC clocks stop, except wake inputs.
// [RQ20] Sleep enters the selected mode only when sleep enable is one.
// [RQ21] Mode 000 idle stops only CPU and flash clocks.
// [RQ22] Interrupt wake holds CPU four extra cycles beyond start-up time.
// [RQ23] Reset during sleep wakes and restarts from the reset vector.
// [RQ24] Accepted wake re-enables gated clocks after start-up delay, before CPU.
`define MODE_IDLE      3'h0
`define MODE_ADC_NR    3'h1
`define MODE_PWR_DOWN  3'h2
`define MODE_PWR_SAVE  3'h3
`define MODE_STANDBY   3'h6
`define MODE_EXT_STBY  3'h7
`define STBY_WAKE_CYC  16'h0006
`define IRQ_EXTRA_CYC  16'h0004
`define WAKE_CNT_W     16
`define CLK_CPU        0
`define CLK_FLASH      1
`define CLK_IO         2
`define CLK_ADC        3
`define CLK_ASY        4
`endif

/* common/sleep_pkg.sv */
package sleep_pkg;
  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STARTUP,
    ST_HOLD
  } sleep_state_t;
  typedef logic [4:0] clk_dom_t;
endpackage

/* common/wake_if.sv */
`timescale 1ns/10ps
interface wake_if;
  logic [2:0] mode;
  logic       async_t2;
  logic       gie;
  logic       wake_irq;
  logic       wake_rst;
  modport ctrl (output mode, output async_t2, output gie, input wake_irq, input wake_rst);
  modport filt (input mode, input async_t2, input gie, output wake_irq, output wake_rst);
endinterface

/* verilog/wake_filter.sv */
`timescale 1ns/10ps
`include "sleep_consts.svh"
module wake_filter (
  // Mode and qualifiers
  wake_if.filt      w,
  // Raw wake sources
  input  wire logic i_adc_done,
  input  wire logic i_twi_match,
  input  wire logic i_t2_ovf,
  input  wire logic i_t2_cmp,
  input  wire logic i_t2_ovf_en,
  input  wire logic i_t2_cmp_en,
  input  wire logic i_spm_ready,
  input  wire logic i_ext_irq_line_0_level,
  input  wire logic i_ext_irq_line_1_level,
  input  wire logic i_ext_irq_line_2,
  input  wire logic i_other_io,
  input  wire logic i_ext_rst,
  input  wire logic i_wdt_rst,
  input  wire logic i_bod_rst
);
  logic t2_ev;
  logic ext_ev;
  // Resets wake from any mode
  assign w.wake_rst = i_ext_rst | i_wdt_rst | i_bod_rst; // [RQ23]
  // Deep modes see only line 2 and the level lines
  assign ext_ev = i_ext_irq_line_2 | i_ext_irq_line_0_level | i_ext_irq_line_1_level; // [RQ13]
  // Timer 2 needs its enable and the global enable to count as a wake
  assign t2_ev = w.gie & ((i_t2_ovf & i_t2_ovf_en) | (i_t2_cmp & i_t2_cmp_en)); // [RQ9]
  // Per-mode source filter
  always_comb begin
    unique case (w.mode)
      `MODE_IDLE:     w.wake_irq = ext_ev | i_twi_match | t2_ev | i_spm_ready
                                   | i_adc_done | i_other_io;
      `MODE_ADC_NR:   w.wake_irq = i_adc_done | i_twi_match | t2_ev | i_spm_ready
                                   | ext_ev; // [RQ3]
      `MODE_PWR_DOWN,
      `MODE_STANDBY:  w.wake_irq = i_twi_match | ext_ev; // [RQ5]
      `MODE_PWR_SAVE,
      `MODE_EXT_STBY: w.wake_irq = i_twi_match | ext_ev | (t2_ev & w.async_t2); // [RQ9]
      default:        w.wake_irq = 1'b0;
    endcase
  end
endmodule

/* verilog/sleep_ctrl.sv */
`timescale 1ns/10ps
`include "sleep_consts.svh"
module sleep_ctrl #(
  parameter logic [15:0] STARTUP_CYC = 16'h0006
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  // Core interface
  input  wire logic        i_sleep_exec,
  input  wire logic        i_sleep_enable_bit,
  input  wire logic [2:0]  i_sleep_mode_select,
  input  wire logic        i_gie,
  input  wire logic        i_crystal_clk,
  // Peripheral configuration
  input  wire logic        i_timer2_async_select,
  input  wire logic        i_adc_enable,
  input  wire logic        i_acmp_enable,
  input  wire logic        i_acmp_uses_ref,
  input  wire logic        i_brownout_enable_fuse,
  input  wire logic        i_wdt_enable,
  // Wake sources
  input  wire logic        i_adc_done,
  input  wire logic        i_twi_match,
  input  wire logic        i_t2_ovf,
  input  wire logic        i_t2_cmp,
  input  wire logic        i_t2_ovf_en,
  input  wire logic        i_t2_cmp_en,
  input  wire logic        i_spm_ready,
  input  wire logic        i_ext_irq_line_0_level,
  input  wire logic        i_ext_irq_line_1_level,
  input  wire logic        i_ext_irq_line_2,
  input  wire logic        i_other_io,
  input  wire logic        i_ext_rst,
  input  wire logic        i_wdt_rst,
  input  wire logic        i_bod_rst,
  // Clock gates, one bit per domain
  output logic [4:0]       o_clk_en,
  output logic             o_main_osc_en,
  output logic             o_timer_osc_en,
  // Analog and buffers
  output logic             o_adc_start,
  output logic             o_adc_extended,
  output logic             o_adc_en,
  output logic             o_acmp_en,
  output logic             o_bod_en,
  output logic             o_wdt_en,
  output logic             o_vref_en,
  output logic             o_inbuf_en,
  // Core status
  output logic             o_asleep,
  output logic             o_cpu_run,
  output logic             o_reset_vector,
  output logic             o_t2_undefined
);
  ////////////////////////////////////////////////////////////////////////////
  wake_if w ();
  sleep_pkg::sleep_state_t state_reg, state_next;
  logic [2:0]              mode_reg, mode_next;
  logic [15:0]             cnt_reg, cnt_next;
  logic                    rst_wake_reg, rst_wake_next;
  logic                    adc_prev_reg, adc_prev_next;
  logic                    ext_conv_reg, ext_conv_next;
  sleep_pkg::clk_dom_t     clk_next;
  logic                    mosc_next, tosc_next, start_next, acmp_next, vref_next, inb_next;
  logic                    t2u_reg, t2u_next;
  logic                    sleeping;
  logic                    gating;

  assign w.mode     = mode_reg;
  assign w.async_t2 = i_timer2_async_select;
  assign w.gie      = i_gie;

  wake_filter u_filt (
    .w            (w),
    .i_adc_done   (i_adc_done),
    .i_twi_match  (i_twi_match),
    .i_t2_ovf     (i_t2_ovf),
    .i_t2_cmp     (i_t2_cmp),
    .i_t2_ovf_en  (i_t2_ovf_en),
    .i_t2_cmp_en  (i_t2_cmp_en),
    .i_spm_ready  (i_spm_ready),
    .i_ext_irq_line_0_level (i_ext_irq_line_0_level),
    .i_ext_irq_line_1_level (i_ext_irq_line_1_level),
    .i_ext_irq_line_2       (i_ext_irq_line_2),
    .i_other_io   (i_other_io),
    .i_ext_rst    (i_ext_rst),
    .i_wdt_rst    (i_wdt_rst),
    .i_bod_rst    (i_bod_rst)
  );

  // Reserved codes, and crystal-only modes without a crystal, fall back to no sleep
  function automatic logic mode_legal(input logic [2:0] m, input logic xtal);
    unique case (m)
      `MODE_IDLE, `MODE_ADC_NR, `MODE_PWR_DOWN, `MODE_PWR_SAVE: mode_legal = 1'b1;
      `MODE_STANDBY, `MODE_EXT_STBY: mode_legal = xtal; // [RQ11] [RQ12]
      default: mode_legal = 1'b0;
    endcase
  endfunction

  // Start-up length depends on whether the oscillator kept running
  function automatic logic [15:0] wake_delay(input logic [2:0] m);
    unique case (m)
      `MODE_PWR_DOWN, `MODE_PWR_SAVE: wake_delay = STARTUP_CYC; // [RQ7]
      `MODE_STANDBY, `MODE_EXT_STBY:  wake_delay = `STBY_WAKE_CYC; // [RQ11] [RQ12]
      default:                        wake_delay = 16'h0001;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: run, sleep, oscillator start-up, four-cycle interrupt hold
  always_comb begin
    state_next    = state_reg;
    mode_next     = mode_reg;
    cnt_next      = cnt_reg;
    rst_wake_next = rst_wake_reg;
    start_next    = 1'b0;
    unique case (state_reg)
      sleep_pkg::ST_RUN: begin
        rst_wake_next = 1'b0;
        if (i_sleep_exec && i_sleep_enable_bit &&
            mode_legal(i_sleep_mode_select, i_crystal_clk)) begin // [RQ20]
          state_next = sleep_pkg::ST_SLEEP;
          mode_next  = i_sleep_mode_select;
          start_next = i_adc_enable && (i_sleep_mode_select == `MODE_ADC_NR); // [RQ2]
        end
      end
      sleep_pkg::ST_SLEEP: begin
        if (w.wake_rst || w.wake_irq) begin
          state_next    = sleep_pkg::ST_STARTUP;
          rst_wake_next = w.wake_rst; // [RQ23]
          cnt_next      = wake_delay(mode_reg); // [RQ7]
        end
      end
      sleep_pkg::ST_STARTUP: begin
        // Clocks return at the end of start-up, then the core is held
        if (cnt_reg <= 16'h0001) begin
          state_next = sleep_pkg::ST_HOLD;
          cnt_next   = `IRQ_EXTRA_CYC; // [RQ22]
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      sleep_pkg::ST_HOLD: begin
        // A reset wake leaves the hold after one cycle and goes to the vector
        if (rst_wake_reg || cnt_reg <= 16'h0001) begin
          state_next = sleep_pkg::ST_RUN;
          mode_next  = `MODE_IDLE;
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      default: state_next = sleep_pkg::ST_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating follows the active mode while asleep or starting up
  assign sleeping = (state_reg == sleep_pkg::ST_SLEEP) || (state_reg == sleep_pkg::ST_STARTUP);
  // Looks at the next state, so analog gates move on the same edge as the clocks
  assign gating = (state_next == sleep_pkg::ST_SLEEP) || (state_next == sleep_pkg::ST_STARTUP);
  always_comb begin
    clk_next  = 5'h1F;
    mosc_next = 1'b1;
    tosc_next = i_timer2_async_select;
    if (sleeping || state_next == sleep_pkg::ST_SLEEP) begin
      unique case (state_next == sleep_pkg::ST_SLEEP && !sleeping ?
                   i_sleep_mode_select : mode_reg)
        `MODE_IDLE: clk_next = 5'h1C; // [RQ21]
        `MODE_ADC_NR: clk_next = 5'h18; // [RQ1]
        `MODE_PWR_DOWN: begin
          clk_next  = 5'h00; // [RQ4]
          mosc_next = 1'b0;
          tosc_next = 1'b0;
        end
        `MODE_PWR_SAVE: begin
          clk_next  = {i_timer2_async_select, 4'h0}; // [RQ8]
          mosc_next = 1'b0;
        end
        `MODE_STANDBY: begin
          clk_next  = 5'h00; // [RQ11]
          tosc_next = 1'b0;
        end
        `MODE_EXT_STBY: clk_next = {i_timer2_async_select, 4'h0}; // [RQ12]
        default: clk_next = 5'h1F;
      endcase
    end
    // Start-up state keeps gates closed; they reopen entering hold
    if (state_next == sleep_pkg::ST_HOLD || state_next == sleep_pkg::ST_RUN) begin
      clk_next  = 5'h1F; // [RQ24]
      mosc_next = 1'b1;
      tosc_next = i_timer2_async_select;
    end
  end

  // Analog side, comparator, reference and input buffers
  always_comb begin
    adc_prev_next = i_adc_enable;
    ext_conv_next = ext_conv_reg;
    if (i_adc_enable && !adc_prev_reg)
      ext_conv_next = 1'b1; // [RQ14]
    else if (i_adc_enable && (start_next || i_adc_done))
      ext_conv_next = 1'b0;
    // Entry edge counts too, else the comparator would drop a cycle late
    acmp_next = i_acmp_enable &&
                (!(gating && mode_next != `MODE_IDLE && mode_next != `MODE_ADC_NR)
                 || i_acmp_uses_ref); // [RQ15]
    vref_next = i_brownout_enable_fuse || (acmp_next && i_acmp_uses_ref)
                || i_adc_enable; // [RQ18]
    // Wake pins stay buffered in the filter path; only other inputs drop
    inb_next  = clk_next[`CLK_IO] || clk_next[`CLK_ADC]; // [RQ19]
    // Leaving power-save with a synchronous timer flags its contents as stale
    t2u_next  = t2u_reg;
    if (state_reg == sleep_pkg::ST_SLEEP && state_next == sleep_pkg::ST_STARTUP)
      t2u_next = (mode_reg == `MODE_PWR_SAVE) && !i_timer2_async_select; // [RQ10]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_reg      <= sleep_pkg::ST_RUN;
      mode_reg       <= `MODE_IDLE;
      cnt_reg        <= 16'h0000;
      rst_wake_reg   <= 1'b0;
      adc_prev_reg   <= 1'b0;
      ext_conv_reg   <= 1'b0;
      t2u_reg        <= 1'b0;
      o_clk_en       <= 5'h1F;
      o_main_osc_en  <= 1'b1;
      o_timer_osc_en <= 1'b0;
      o_adc_start    <= 1'b0;
      o_adc_extended <= 1'b0;
      o_adc_en       <= 1'b0;
      o_acmp_en      <= 1'b0;
      o_bod_en       <= 1'b0;
      o_wdt_en       <= 1'b0;
      o_vref_en      <= 1'b0;
      o_inbuf_en     <= 1'b1;
      o_asleep       <= 1'b0;
      o_cpu_run      <= 1'b1;
      o_reset_vector <= 1'b0;
      o_t2_undefined <= 1'b0;
    end else begin
      state_reg      <= state_next;
      mode_reg       <= mode_next;
      cnt_reg        <= cnt_next;
      rst_wake_reg   <= rst_wake_next;
      adc_prev_reg   <= adc_prev_next;
      ext_conv_reg   <= ext_conv_next;
      t2u_reg        <= t2u_next;
      o_clk_en       <= clk_next;
      o_main_osc_en  <= mosc_next;
      o_timer_osc_en <= tosc_next;
      o_adc_start    <= start_next;
      o_adc_extended <= ext_conv_next;
      o_adc_en       <= i_adc_enable; // [RQ14]
      o_acmp_en      <= acmp_next;
      o_bod_en       <= i_brownout_enable_fuse; // [RQ16]
      o_wdt_en       <= i_wdt_enable; // [RQ17]
      o_vref_en      <= vref_next;
      o_inbuf_en     <= inb_next;
      o_asleep       <= (state_next != sleep_pkg::ST_RUN);
      o_cpu_run      <= (state_next == sleep_pkg::ST_RUN);
      o_reset_vector <= (state_reg == sleep_pkg::ST_HOLD) && rst_wake_reg
                        && (state_next == sleep_pkg::ST_RUN); // [RQ23]
      o_t2_undefined <= t2u_next;
    end
  end
endmodule

/* bench/sleep_ctrl_asserts.sv */
`timescale 1ns/10ps
module sleep_ctrl_asserts #(
  parameter logic [15:0] STARTUP_CYC = 16'h0006
) (
  // Clock and reset
  input wire logic       i_mclk,
  input wire logic       i_srst,
  // Core request and configuration
  input wire logic       i_sleep_exec,
  input wire logic       i_sleep_enable_bit,
  input wire logic [2:0] i_sleep_mode_select,
  input wire logic       i_crystal_clk,
  input wire logic       i_adc_enable,
  input wire logic       i_acmp_enable,
  input wire logic       i_acmp_uses_ref,
  input wire logic       i_brownout_enable_fuse,
  input wire logic       i_wdt_enable,
  // Watched outputs
  input wire logic [4:0] o_clk_en,
  input wire logic       o_main_osc_en,
  input wire logic       o_adc_start,
  input wire logic       o_acmp_en,
  input wire logic       o_bod_en,
  input wire logic       o_wdt_en,
  input wire logic       o_vref_en,
  input wire logic       o_inbuf_en,
  input wire logic       o_asleep,
  input wire logic       o_cpu_run,
  input wire logic       o_reset_vector
);
  logic       go;
  logic [2:0] ms;

  // A sleep request only counts while the core is running
  assign go = i_sleep_exec && i_sleep_enable_bit && o_cpu_run;
  assign ms = i_sleep_mode_select;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  ////////////////////////////////////////////////////////////////////////////
  a_idle_gate : assert property (go && ms == 3'h0 |=> o_asleep && o_clk_en == 5'h1C)
    else $error("idle gating wrong");
  a_nr_gate : assert property (go && ms == 3'h1 |=>
    o_clk_en == 5'h18 && o_adc_start == $past(i_adc_enable))
    else $error("noise reduction gating wrong");
  a_pd_gate : assert property (go && ms == 3'h2 |=> o_clk_en == 5'h00 && !o_main_osc_en)
    else $error("power-down gating wrong");
  a_stby_osc : assert property (go && ms[2:1] == 2'b11 && i_crystal_clk |=>
    o_asleep && o_main_osc_en && o_clk_en[3:0] == 4'h0)
    else $error("standby oscillator wrong");
  a_no_enable : assert property (i_sleep_exec && !i_sleep_enable_bit && o_cpu_run |=>
    !o_asleep)
    else $error("slept without enable");
  a_bad_mode : assert property (go && (ms[2:1] == 2'b10 ||
    (ms[2:1] == 2'b11 && !i_crystal_clk)) |=> o_cpu_run && !o_asleep)
    else $error("illegal mode entered");
  // Registered levels lag by one cycle, so only judge them with steady inputs
  a_keep_bod : assert property (o_asleep && $stable(i_brownout_enable_fuse) &&
    $stable(i_wdt_enable) |-> o_bod_en == i_brownout_enable_fuse && o_wdt_en == i_wdt_enable)
    else $error("detector or watchdog dropped");
  a_vref_need : assert property (o_asleep && $stable({i_brownout_enable_fuse,
    i_adc_enable, i_acmp_enable, i_acmp_uses_ref}) |-> o_vref_en ==
    (i_brownout_enable_fuse || i_adc_enable || (i_acmp_enable && i_acmp_uses_ref)))
    else $error("reference enable wrong");
  a_acmp_deep : assert property (o_asleep && !o_clk_en[3] &&
    $stable({i_acmp_enable, i_acmp_uses_ref}) |->
    o_acmp_en == (i_acmp_enable && i_acmp_uses_ref))
    else $error("comparator not disabled");
  a_inbuf_off : assert property (o_asleep |-> o_inbuf_en == (o_clk_en[2] || o_clk_en[3]))
    else $error("input buffer enable wrong");
  a_irq_hold : assert property ($rose(o_cpu_run) && !o_reset_vector |->
    $past(o_clk_en, 3) == 5'h1F)
    else $error("interrupt hold too short");
  a_rst_vector : assert property (o_reset_vector |->
    $rose(o_cpu_run) && $past(o_clk_en) == 5'h1F)
    else $error("reset vector pulse misplaced");
endmodule

/* bench/wake_src_model.sv */
`timescale 1ns/10ps
module wake_src_model (
  // Clock, reset and bench requests
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_fire,
  input  wire logic [3:0]  i_pick,
  // Core status
  input  wire logic        i_cpu_run,
  // Wake sources, one bit each
  output logic      [11:0] o_src
);
  logic [11:0] src_reg;
  logic [11:0] src_next;
  logic        run_reg;

  // Sources stay raised until the core runs again, so a level wake is
  // never lost while the clocks restart; a refused one is dropped too
  always_comb begin
    src_next = src_reg;
    if (i_cpu_run && !run_reg) begin
      src_next = 12'h000;
    end
    if (i_fire) begin
      src_next = src_reg | (12'h001 << i_pick);
    end
  end

  // Register stage
  always_ff @(posedge i_mclk) begin
    src_reg <= i_srst ? 12'h000 : src_next;
    run_reg <= i_cpu_run;
  end
  assign o_src = src_reg;
endmodule

/* bench/sleep_mode_clock_gating_tb.sv */
`timescale 1ns/10ps
module sleep_mode_clock_gating_tb;
  logic        i_mclk;
  logic        i_srst;
  logic        exec, se, gie, xtal, async, adc, acmp, uref, bodf, wdt, t2en, fire;
  logic [2:0]  mode;
  logic [3:0]  pick;
  logic [11:0] src;
  logic [4:0]  clk_en;
  logic        mosc, tosc, astart, aext, adc_en, acmp_en, bod_en, wdt_en, vref_en;
  logic        inbuf, asleep, cpu_run, rvec, t2u;
  int          error_cnt = 0;
  int          n_tests = 0;

  // Short start-up count keeps the run brief; six stays distinct for standby
  sleep_ctrl #(.STARTUP_CYC(16'h0003)) dut_u (
    .i_mclk, .i_srst, .i_sleep_exec(exec), .i_sleep_enable_bit(se),
    .i_sleep_mode_select(mode), .i_gie(gie), .i_crystal_clk(xtal),
    .i_timer2_async_select(async), .i_adc_enable(adc), .i_acmp_enable(acmp),
    .i_acmp_uses_ref(uref), .i_brownout_enable_fuse(bodf), .i_wdt_enable(wdt),
    .i_adc_done(src[0]), .i_twi_match(src[1]), .i_t2_ovf(src[2]), .i_t2_cmp(src[3]),
    .i_t2_ovf_en(t2en), .i_t2_cmp_en(t2en), .i_spm_ready(src[4]),
    .i_ext_irq_line_0_level(src[5]), .i_ext_irq_line_1_level(src[6]), .i_ext_irq_line_2(src[7]),
    .i_other_io(src[8]), .i_ext_rst(src[9]), .i_wdt_rst(src[10]), .i_bod_rst(src[11]),
    .o_clk_en(clk_en), .o_main_osc_en(mosc), .o_timer_osc_en(tosc),
    .o_adc_start(astart), .o_adc_extended(aext), .o_adc_en(adc_en),
    .o_acmp_en(acmp_en), .o_bod_en(bod_en), .o_wdt_en(wdt_en), .o_vref_en(vref_en),
    .o_inbuf_en(inbuf), .o_asleep(asleep), .o_cpu_run(cpu_run),
    .o_reset_vector(rvec), .o_t2_undefined(t2u));

  wake_src_model src_u (.i_mclk, .i_srst, .i_fire(fire), .i_pick(pick),
    .i_cpu_run(cpu_run), .o_src(src));

  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [4:0] exp_clk(input logic [2:0] m, input logic a);
    case (m)
      3'h0: return 5'h1C;
      3'h1: return 5'h18;
      3'h3, 3'h7: return {a, 4'h0};
      default: return 5'h00;
    endcase
  endfunction

  // Start-up length by mode, matching the parameter set above
  function automatic int nstart(input logic [2:0] m);
    if (m == 3'h2 || m == 3'h3) return 3;
    return (m[2] && m[1]) ? 6 : 1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Core side: enable bit and sleep pulse on the same edge; checks land after the take
  task automatic go_sleep(input logic [2:0] m, input logic a, g, s, x);
    @(posedge i_mclk);
    {async, gie, se, xtal} <= {a, g, s, x};
    mode <= m;
    exec <= 1'b1;
    @(posedge i_mclk);
    exec <= 1'b0;
    #1;
  endtask

  task automatic fire_src(input logic [3:0] s);
    @(posedge i_mclk);
    pick <= s;
    fire <= 1'b1;
    @(posedge i_mclk);
    fire <= 1'b0;
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (cpu_run !== 1'b1 && n < 30) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
  endtask

  task automatic refuse(input logic [2:0] m, input logic s, input logic x);
    go_sleep(m, 1'b0, 1'b1, s, x);
    chk(cpu_run === 1'b1 && asleep === 1'b0, "request not refused");
  endtask

  // Sleep in mode m, raise source s, expect a wake or not
  task automatic run_case(input logic [2:0] m, input logic [3:0] s, input logic a, g, e);
    int n;
    int lo;
    go_sleep(m, a, g, 1'b1, 1'b1);
    chk(asleep === 1'b1 && clk_en === exp_clk(m, a), "clock gating");
    chk(mosc === (m[2] || !m[1]) && tosc === (a && (m[0] || !m[1])), "osc");
    chk(adc_en === adc, "converter enable");
    chk(acmp_en === (acmp && (uref || !m[1])), "comparator enable");
    chk(bod_en === bodf && wdt_en === wdt, "detector or watchdog");
    chk(vref_en === (bodf || adc || (acmp && uref)), "reference enable");
    chk(inbuf === !m[1], "input buffers");
    if (m == 3'h1) chk(astart === adc, "conversion start");
    fire_src(s);
    wait_run(n);
    // One edge of source latency, start-up, then four hold cycles or one
    lo = nstart(m) + ((s > 4'h8) ? 2 : 5);
    if (e) begin
      chk(n == lo && rvec === (s > 4'h8), "wake timing");
    end else begin
      chk(cpu_run === 1'b0, "wrong wake source");
      fire_src(4'h9);
      wait_run(n);
      chk(cpu_run === 1'b1 && rvec === 1'b1, "reset wake");
    end
    if (m == 3'h3 && !a) chk(t2u === 1'b1, "timer state flag");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {exec, se, async, adc, uref, bodf, fire} = 7'h00;
    {gie, xtal, acmp, wdt, t2en, i_srst} = 6'h3F;
    mode = 3'h0;
    pick = 4'h0;
    repeat (8) @(posedge i_mclk);
    #1;
    chk(clk_en === 5'h1F && cpu_run === 1'b1 && inbuf === 1'b1, "reset values");
    @(posedge i_mclk);
    i_srst <= 1'b0;
    refuse(3'h2, 1'b0, 1'b1);
    refuse(3'h4, 1'b1, 1'b1);
    refuse(3'h5, 1'b1, 1'b1);
    refuse(3'h6, 1'b1, 1'b0);
    refuse(3'h7, 1'b1, 1'b0);
    run_case(3'h0, 4'h8, 1'b0, 1'b1, 1'b1);
    run_case(3'h1, 4'h8, 1'b0, 1'b1, 1'b0);
    run_case(3'h2, 4'h7, 1'b0, 1'b1, 1'b1);
    run_case(3'h2, 4'h0, 1'b0, 1'b1, 1'b0);
    run_case(3'h2, 4'hA, 1'b0, 1'b1, 1'b1);
    run_case(3'h3, 4'h2, 1'b1, 1'b1, 1'b1);
    run_case(3'h3, 4'h3, 1'b1, 1'b0, 1'b0);
    @(posedge i_mclk);
    t2en <= 1'b0;
    run_case(3'h3, 4'h2, 1'b1, 1'b1, 1'b0);
    @(posedge i_mclk);
    t2en <= 1'b1;
    run_case(3'h3, 4'h5, 1'b0, 1'b1, 1'b1);
    run_case(3'h6, 4'h1, 1'b0, 1'b1, 1'b1);
    run_case(3'h6, 4'h2, 1'b1, 1'b1, 1'b0);
    run_case(3'h7, 4'h6, 1'b1, 1'b1, 1'b1);
    run_case(3'h7, 4'h3, 1'b1, 1'b1, 1'b1);
    @(posedge i_mclk);
    adc <= 1'b1;
    repeat (2) @(posedge i_mclk);
    #1;
    chk(aext === 1'b1, "extended conversion");
    run_case(3'h1, 4'h0, 1'b0, 1'b1, 1'b1);
    run_case(3'h1, 4'h4, 1'b0, 1'b1, 1'b1);
    run_case(3'h1, 4'hB, 1'b0, 1'b1, 1'b1);
    @(posedge i_mclk);
    {uref, bodf} <= 2'h3;
    run_case(3'h2, 4'h6, 1'b0, 1'b1, 1'b1);
    stop_test();
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge i_mclk);
    error_cnt++;
    $display("mismatch at %0t: run timed out", $time);
    stop_test();
  end
endmodule

bind sleep_ctrl sleep_ctrl_asserts #(.STARTUP_CYC(STARTUP_CYC)) chk_u (
  .i_mclk, .i_srst, .i_sleep_exec, .i_sleep_enable_bit, .i_sleep_mode_select,
  .i_crystal_clk, .i_adc_enable, .i_acmp_enable, .i_acmp_uses_ref,
  .i_brownout_enable_fuse, .i_wdt_enable, .o_clk_en, .o_main_osc_en, .o_adc_start,
  .o_acmp_en, .o_bod_en, .o_wdt_en, .o_vref_en, .o_inbuf_en, .o_asleep, .o_cpu_run,
  .o_reset_vector);
